/* verilog/pkt_list_pkg.sv */
package pkt_list_pkg;
	localparam logic [7:0] MIN_OFS = 8'h00;
	localparam logic [7:0] MAX_OFS = 8'h04;
	localparam logic [7:0] CTRL_OFS = 8'h08;
	localparam logic [7:0] STAT_OFS = 8'h0c;
	localparam int RUN_W = 24;
	localparam logic [23:0] RUN_RESET = 24'h010000;
	localparam logic [31:0] MASTER_SUSP_BASE = 32'h01010000;
	localparam logic [31:0] PP_SUSP_BASE = 32'h01000000;
	localparam int PP_SHIFT = 12;
	localparam logic [31:0] LIST_START_OFS = 32'h00000080;
	localparam logic [3:0] LAST_DWORD = 4'hf;
	localparam int DWORD_SHIFT = 3;
	localparam int ALIGN_BITS = 7;
	localparam int SUSP_LSB = 0;
	localparam int CAUSE_LSB = 4;
	localparam int ID_LSB = 8;
	localparam int MIN_DONE_BIT = 12;
	localparam int EXT_BIT = 16;
	typedef enum logic [2:0] {
		C_NONE, C_PREEMPT, C_TIMEOUT, C_REQUEST, C_FAULT, C_ERROR
	} cause_t;
	typedef enum logic [2:0] {
		S_IDLE, S_LOAD, S_RUN, S_DRAIN, S_SAVE, S_LINK, S_FINISH
	} state_t;
	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [63:0] data;
		logic [1:0] prio;
	} pram_wr_t;
endpackage

/* verilog/run_timer.sv */
`timescale 1ns/10ps
module run_timer #(
	parameter int W = 24
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic start_i,
	input wire logic tick_i,
	input wire logic [W-1:0] min_i,
	input wire logic [W-1:0] max_i,
	output logic min_done_o,
	output logic timeout_o
);
	logic [W-1:0] cnt_q;
	logic phase_q;
	wire at_zero = (cnt_q == '0);

	if (W < 2) begin : g_chk
		$error("run_timer width too small");
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q <= '0;
			phase_q <= 1'b0;
		end else if (start_i) begin
			cnt_q <= min_i; // [R24]
			phase_q <= 1'b0;
		end else if (tick_i && !at_zero) begin
			cnt_q <= cnt_q - 1'b1; // [R24]
		end else if (tick_i && !phase_q) begin
			cnt_q <= max_i; // [R25]
			phase_q <= 1'b1;
		end
	end

	assign min_done_o = phase_q | at_zero; // [R15]
	assign timeout_o = phase_q & at_zero; // [R25]
endmodule

/* verilog/packet_list_suspend_control.sv */
`timescale 1ns/10ps
// How it works
// [R1] Interrupting services stall only the shared side
// [R2] External transfer finishes before cache or direct access
// [R3] Urgent master transfer blocks cache per priority mode
// [R4] Internal lists suspend on five causes
// [R5] Save state, then point list start at area
// [R6] Preempted transfer keeps its round-robin token
// [R7] Preempt during load abandons load, no suspend
// [R8] Other suspend causes advance round-robin token
// [R9] Interrupt bit gives end flag, then next entry
// [R10] Stop bit gives end flag and ends list
// [R11] External completions show status, no interrupt
// [R12] Next address written to list start always
// [R13] Suspended table also reloads saved internal state
// [R14] Error stops data, suspends, flags, clears queue
// [R15] Preempt after minimum; time-out after min plus max
// [R16] Requester suspend and source/destination faults suspend
// [R17] Suspend waits for pending column accesses
// [R18] Save priority follows preemptor or original
// [R19] External transfers never suspend, no area
// [R20] Staging buffer saved, not drained
// [R21] Resubmitted suspend copy must be 128-byte aligned
// [R22] Sixteen doublewords: eight table, eight internal
// [R23] Ascending writes, list pointer written last
// [R24] Counter loads minimum, counts active cycles only
// [R25] Zero reloads maximum; second zero is time-out
// [R26] Run-length registers reset to 0x010000
module packet_list_suspend_control #(
	parameter int NPP = 4
) (
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic PT_REQ_I,
	input wire logic [2:0] PT_ID_I,
	input wire logic [1:0] PT_PRIO_I,
	input wire logic PT_EXT_I,
	input wire logic PT_URGENT_I,
	input wire logic [31:0] PT_LIST_I,
	output logic PT_ACK_O,
	input wire logic HIPRI_REQ_I,
	input wire logic [1:0] HIPRI_PRIO_I,
	output logic LOAD_O,
	output logic RESTORE_O,
	input wire logic LOAD_DONE_I,
	input wire logic LOAD_SUSP_I,
	output logic XFER_O,
	input wire logic DATA_CYCLE_I,
	input wire logic XFER_DONE_I,
	input wire logic IRQ_BIT_I,
	input wire logic STOP_BIT_I,
	input wire logic [31:0] NEXT_ADDR_I,
	input wire logic SUSP_REQ_I,
	input wire logic SRC_FAULT_I,
	input wire logic DST_FAULT_I,
	input wire logic XFER_ERR_I,
	input wire logic COL_PEND_I,
	input wire logic LAST_COL_I,
	input wire logic SVC_REQ_I,
	input wire logic SVC_NOCNT_I,
	input wire logic SVC_XBAR_I,
	input wire logic SVC_EXT_I,
	input wire logic SRC_EXT_I,
	input wire logic DST_EXT_I,
	output logic SRC_STALL_O,
	output logic DST_STALL_O,
	input wire logic CACHE_REQ_I,
	input wire logic CACHE_MASTER_I,
	output logic CACHE_GRANT_O,
	output logic [3:0] SAVE_IDX_O,
	input wire logic [63:0] SAVE_DATA_I,
	output pkt_list_pkg::pram_wr_t PRAM_WR_O,
	input wire logic PRAM_READY_I,
	output logic TOKEN_ADV_O,
	output logic LOAD_ABORT_O,
	output logic MASTER_END_O,
	output logic [NPP-1:0] PP_END_O,
	output logic MASTER_ERR_O,
	output logic [NPP-1:0] PP_ERR_O,
	output logic QUEUE_CLR_O,
	output logic XPT_DONE_STAT_O
);
	if (NPP < 1 || NPP > 7) begin : g_chk
		$error("NPP must be 1 to 7");
	end

	pkt_list_pkg::state_t state_q, state_d;
	pkt_list_pkg::cause_t cause_q, cause_d;
	logic [23:0] min_q, max_q;
	logic hipri_mode_q;
	logic [31:0] rdata_q;
	logic [2:0] id_q;
	logic [1:0] prio_q, save_prio_q;
	logic ext_q, urgent_q, irq_q, stop_q;
	logic [31:0] list_q, next_q;
	logic [3:0] idx_q;
	logic [NPP:0] end_q, err_q;
	logic token_q, abort_q, qclr_q, ack_q;

	// Register bus decode
	wire setup = PSEL_I & ~PENABLE_I;
	wire access = PSEL_I & PENABLE_I;
	wire hit_min = (PADDR_I == pkt_list_pkg::MIN_OFS);
	wire hit_max = (PADDR_I == pkt_list_pkg::MAX_OFS);
	wire hit_ctrl = (PADDR_I == pkt_list_pkg::CTRL_OFS);
	wire hit_stat = (PADDR_I == pkt_list_pkg::STAT_OFS);
	wire hit = hit_min | hit_max | hit_ctrl | hit_stat;
	wire wr = access & PWRITE_I & hit;

	// Timer and suspend conditions
	wire min_done, timeout;
	wire in_run = (state_q == pkt_list_pkg::S_RUN);
	wire in_load = (state_q == pkt_list_pkg::S_LOAD);
	wire fault = SRC_FAULT_I | DST_FAULT_I;
	wire preempt = HIPRI_REQ_I & min_done;
	wire susp_any = XFER_ERR_I | fault | SUSP_REQ_I | timeout | preempt;
	wire misalign = LOAD_SUSP_I && (list_q[pkt_list_pkg::ALIGN_BITS-1:0] != '0);
	wire load_ok = in_load & LOAD_DONE_I & ~HIPRI_REQ_I & ~misalign;
	wire load_bad = in_load & LOAD_DONE_I & ~HIPRI_REQ_I & misalign;

	// Service arbitration against the running transfer
	wire mode_block = hipri_mode_q ? ~CACHE_MASTER_I : CACHE_MASTER_I;
	wire urgent_block = urgent_q & (id_q == 3'd0) & mode_block; // [R3]
	wire cache_block = in_run & (ext_q | urgent_block); // [R2]
	wire cache_go = CACHE_REQ_I & ~cache_block;
	wire svc_go = SVC_REQ_I & in_run;
	wire tick = in_run & DATA_CYCLE_I & ~cache_go & ~(SVC_REQ_I & SVC_NOCNT_I); // [R24]

	// Parameter RAM addresses of the requester
	wire [31:0] pp_area = pkt_list_pkg::PP_SUSP_BASE
		| ({29'd0, id_q - 3'd1} << pkt_list_pkg::PP_SHIFT);
	wire [31:0] susp_base = (id_q == 3'd0) ? pkt_list_pkg::MASTER_SUSP_BASE : pp_area;
	wire [31:0] list_loc = susp_base + pkt_list_pkg::LIST_START_OFS;
	wire [31:0] save_addr = susp_base + ({28'd0, idx_q} << pkt_list_pkg::DWORD_SHIFT);
	wire [31:0] opt_word = {SAVE_DATA_I[31:3], cause_q}; // [R22]
	wire [63:0] word0 = {list_q, opt_word};
	wire [63:0] save_word = (idx_q == 4'd0) ? word0 : SAVE_DATA_I;
	wire in_save = (state_q == pkt_list_pkg::S_SAVE);
	wire in_link = (state_q == pkt_list_pkg::S_LINK);
	wire in_fin = (state_q == pkt_list_pkg::S_FINISH);
	wire last_save = in_save & PRAM_READY_I & (idx_q == pkt_list_pkg::LAST_DWORD);
	wire link_done = in_link & PRAM_READY_I;
	wire fin_done = in_fin & PRAM_READY_I;
	wire err_cause = (cause_q == pkt_list_pkg::C_ERROR);

	run_timer #(
		.W(pkt_list_pkg::RUN_W)
	) u_timer (
		.clk_i(CLK_I),
		.rstn_i(RSTN_I),
		.start_i(load_ok),
		.tick_i(tick),
		.min_i(min_q),
		.max_i(max_q),
		.min_done_o(min_done),
		.timeout_o(timeout)
	);

	always_comb begin
		cause_d = pkt_list_pkg::C_NONE;
		if (XFER_ERR_I) begin
			cause_d = pkt_list_pkg::C_ERROR;
		end else if (fault) begin
			cause_d = pkt_list_pkg::C_FAULT;
		end else if (SUSP_REQ_I) begin
			cause_d = pkt_list_pkg::C_REQUEST;
		end else if (timeout) begin
			cause_d = pkt_list_pkg::C_TIMEOUT;
		end else if (preempt) begin
			cause_d = pkt_list_pkg::C_PREEMPT;
		end
	end

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			pkt_list_pkg::S_IDLE: begin
				if (PT_REQ_I) begin
					state_d = pkt_list_pkg::S_LOAD;
				end
			end
			pkt_list_pkg::S_LOAD: begin
				if (HIPRI_REQ_I && !ext_q) begin
					state_d = pkt_list_pkg::S_IDLE; // [R7]
				end else if (load_bad) begin
					state_d = pkt_list_pkg::S_IDLE; // [R21]
				end else if (load_ok) begin
					state_d = pkt_list_pkg::S_RUN;
				end
			end
			pkt_list_pkg::S_RUN: begin
				if (ext_q) begin
					if (XFER_ERR_I || XFER_DONE_I) begin
						state_d = pkt_list_pkg::S_IDLE; // [R19]
					end
				end else if (susp_any) begin
					state_d = pkt_list_pkg::S_DRAIN; // [R4] [R16]
				end else if (XFER_DONE_I) begin
					state_d = pkt_list_pkg::S_FINISH;
				end
			end
			pkt_list_pkg::S_DRAIN: begin
				if (!COL_PEND_I) begin
					state_d = pkt_list_pkg::S_SAVE; // [R17] [R20]
				end
			end
			pkt_list_pkg::S_SAVE: begin
				if (last_save) begin
					state_d = pkt_list_pkg::S_LINK; // [R23]
				end
			end
			pkt_list_pkg::S_LINK: begin
				if (link_done) begin
					state_d = pkt_list_pkg::S_IDLE;
				end
			end
			pkt_list_pkg::S_FINISH: begin
				if (fin_done) begin
					state_d = stop_q ? pkt_list_pkg::S_IDLE : pkt_list_pkg::S_LOAD; // [R9] [R10]
				end
			end
		endcase
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state_q <= pkt_list_pkg::S_IDLE;
			cause_q <= pkt_list_pkg::C_NONE;
		end else begin
			state_q <= state_d;
			if (in_run && susp_any) begin
				cause_q <= cause_d;
			end
		end
	end

	// Request capture and list pointer tracking
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			id_q <= 3'd0;
			prio_q <= 2'd0;
			ext_q <= 1'b0;
			urgent_q <= 1'b0;
			list_q <= 32'h0;
		end else if (state_q == pkt_list_pkg::S_IDLE && PT_REQ_I) begin
			id_q <= PT_ID_I;
			prio_q <= PT_PRIO_I;
			ext_q <= PT_EXT_I;
			urgent_q <= PT_URGENT_I;
			list_q <= PT_LIST_I;
		end else if (fin_done) begin
			list_q <= next_q;
		end
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			irq_q <= 1'b0;
			stop_q <= 1'b0;
			next_q <= 32'h0;
			save_prio_q <= 2'd0;
		end else if (in_run) begin
			irq_q <= IRQ_BIT_I;
			stop_q <= STOP_BIT_I;
			next_q <= NEXT_ADDR_I;
			save_prio_q <= (cause_d == pkt_list_pkg::C_PREEMPT) ? HIPRI_PRIO_I : prio_q; // [R18]
		end
	end

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			idx_q <= 4'd0;
		end else if (!in_save) begin
			idx_q <= 4'd0;
		end else if (PRAM_READY_I) begin
			idx_q <= idx_q + 4'd1; // [R23]
		end
	end

	// Event pulses towards requesters and arbiter
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			end_q <= '0;
			err_q <= '0;
			token_q <= 1'b0;
			abort_q <= 1'b0;
			qclr_q <= 1'b0;
			ack_q <= 1'b0;
		end else begin
			end_q <= '0;
			err_q <= '0;
			if (fin_done && (irq_q || stop_q)) begin
				end_q[id_q] <= 1'b1; // [R9] [R10]
			end
			if ((link_done && err_cause) || load_bad) begin
				err_q[id_q] <= 1'b1; // [R14]
			end
			qclr_q <= (link_done && err_cause) || load_bad; // [R14]
			token_q <= link_done && (cause_q != pkt_list_pkg::C_PREEMPT); // [R6] [R8]
			abort_q <= in_load && HIPRI_REQ_I && !ext_q; // [R7]
			ack_q <= state_q == pkt_list_pkg::S_IDLE && PT_REQ_I;
		end
	end

	// Register file
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			min_q <= pkt_list_pkg::RUN_RESET; // [R26]
			max_q <= pkt_list_pkg::RUN_RESET; // [R26]
			hipri_mode_q <= 1'b0;
		end else begin
			if (wr && hit_min) begin
				min_q <= PWDATA_I[23:0];
			end
			if (wr && hit_max) begin
				max_q <= PWDATA_I[23:0];
			end
			if (wr && hit_ctrl) begin
				hipri_mode_q <= PWDATA_I[0];
			end
		end
	end

	logic [31:0] stat_word;
	always_comb begin
		stat_word = 32'h0;
		stat_word[pkt_list_pkg::SUSP_LSB +: 3] = state_q;
		stat_word[pkt_list_pkg::CAUSE_LSB +: 3] = cause_q;
		stat_word[pkt_list_pkg::ID_LSB +: 3] = id_q;
		stat_word[pkt_list_pkg::MIN_DONE_BIT] = min_done;
		stat_word[pkt_list_pkg::EXT_BIT] = ext_q;
	end

	wire [31:0] rd_mux = hit_min ? {8'h0, min_q} :
		hit_max ? {8'h0, max_q} :
		hit_ctrl ? {31'h0, hipri_mode_q} :
		hit_stat ? stat_word : 32'h0;

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rdata_q <= 32'h0;
		end else if (setup) begin
			rdata_q <= rd_mux;
		end
	end

	assign PRDATA_O = rdata_q;
	assign PREADY_O = 1'b1;
	assign PSLVERR_O = access & ~hit;

	// Datapath handshakes
	assign PT_ACK_O = ack_q;
	assign LOAD_O = in_load;
	assign RESTORE_O = in_load & LOAD_SUSP_I; // [R13]
	assign XFER_O = in_run; // [R14]
	assign SRC_STALL_O = cache_go | (svc_go & (SRC_EXT_I ? SVC_EXT_I : SVC_XBAR_I)); // [R1]
	assign DST_STALL_O = cache_go | (svc_go & (DST_EXT_I ? SVC_EXT_I : SVC_XBAR_I)); // [R1]
	assign CACHE_GRANT_O = cache_go;
	assign SAVE_IDX_O = idx_q;
	assign XPT_DONE_STAT_O = in_run & ext_q & LAST_COL_I; // [R11]

	always_comb begin
		PRAM_WR_O.valid = in_save | in_link | in_fin;
		PRAM_WR_O.prio = in_fin ? prio_q : save_prio_q; // [R18]
		PRAM_WR_O.addr = in_save ? save_addr : list_loc;
		PRAM_WR_O.data = 64'h0;
		if (in_save) begin
			PRAM_WR_O.data = save_word; // [R22]
		end else if (in_link) begin
			PRAM_WR_O.data = {32'h0, susp_base}; // [R5]
		end else if (in_fin) begin
			PRAM_WR_O.data = {32'h0, next_q}; // [R12]
		end
	end

	assign TOKEN_ADV_O = token_q;
	assign LOAD_ABORT_O = abort_q;
	assign MASTER_END_O = end_q[0];
	assign PP_END_O = end_q[NPP:1];
	assign MASTER_ERR_O = err_q[0];
	assign PP_ERR_O = err_q[NPP:1];
	assign QUEUE_CLR_O = qclr_q;

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);

	sequence s_suspend_start;
		in_run && !ext_q && susp_any;
	endsequence

	sequence s_drain_over;
		(state_q == pkt_list_pkg::S_DRAIN) && !COL_PEND_I;
	endsequence

	a_suspend_enter: assert property (s_suspend_start |=> state_q == pkt_list_pkg::S_DRAIN) // [R4]
		else $error("suspend condition did not start suspension");
	a_drain_wait: assert property ((state_q == pkt_list_pkg::S_DRAIN) && COL_PEND_I
		|=> state_q == pkt_list_pkg::S_DRAIN) // [R17]
		else $error("suspension left drain with columns pending");
	a_drain_save: assert property (s_drain_over |=> in_save && idx_q == 4'd0) // [R23]
		else $error("save did not start at first doubleword");
	a_ext_nosave: assert property (ext_q |-> !in_save && !in_link) // [R19]
		else $error("external transfer saved state");
	a_link_after: assert property (last_save |=> in_link) // [R5]
		else $error("list pointer not written after save");
	a_token_kept: assert property (link_done && cause_q == pkt_list_pkg::C_PREEMPT
		|=> !TOKEN_ADV_O) // [R6]
		else $error("token advanced on preemption");
	a_token_adv: assert property (link_done && cause_q == pkt_list_pkg::C_TIMEOUT
		|=> TOKEN_ADV_O) // [R8]
		else $error("token kept on time-out");
	a_load_abort: assert property (in_load && HIPRI_REQ_I && !ext_q
		|=> LOAD_ABORT_O && state_q == pkt_list_pkg::S_IDLE) // [R7]
		else $error("load not abandoned");
	a_error_flags: assert property (link_done && err_cause |=> QUEUE_CLR_O && err_q[id_q]) // [R14]
		else $error("error flag or queue clear missing");
	a_no_early_preempt: assert property (in_run && !ext_q && HIPRI_REQ_I && !min_done
		&& !(XFER_ERR_I || fault || SUSP_REQ_I || timeout) |=> state_q != pkt_list_pkg::S_DRAIN)
		// [R15]
		else $error("preempted before minimum run");
	a_ext_block: assert property (in_run && ext_q |-> !CACHE_GRANT_O) // [R2]
		else $error("cache granted during external transfer");
endmodule

/* testbench/pkt_far_model.sv */
`timescale 1ns/10ps
module pkt_far_model (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic load_i,
	input wire logic pram_valid_i,
	input wire logic [3:0] save_idx_i,
	output logic load_done_o,
	output logic pram_ready_o,
	output logic [63:0] save_data_o
);
	logic [1:0] wait_q;
	// Index in the low nibble so each saved word can be traced
	assign save_data_o = {16'hc3c3, 44'h0, save_idx_i};
	// Table fetch takes three cycles; parameter RAM stalls one cycle per write
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wait_q <= 2'h0;
			load_done_o <= 1'b0;
			pram_ready_o <= 1'b0;
		end else begin
			wait_q <= (load_i && !load_done_o) ? wait_q + 2'h1 : 2'h0;
			load_done_o <= load_i && !load_done_o && wait_q == 2'h2;
			pram_ready_o <= pram_valid_i && !pram_ready_o;
		end
	end
endmodule

/* testbench/packet_list_suspend_control_test.sv */
`timescale 1ns/10ps
module packet_list_suspend_control_test;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, req, ext, urg, ack, hip, load;
	logic ldone, lsusp, xfer, dcyc, xdone, irq, stop, sreq, sflt, dflt, xerr, colp, lcol;
	logic svc, nocnt, sxbar, sext, srcx, dstx, sstall, dstall, creq, cmas, cgnt, prdy;
	logic tok_o, abrt_o, mend_o, merr_o, qclr_o, xstat, rest;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, list, nxt, r;
	logic [2:0] id;
	logic [1:0] prio, hprio;
	logic [3:0] sidx, pend_o, perr_o;
	logic [63:0] sdata;
	logic e;
	pkt_list_pkg::pram_wr_t pw;
	logic [97:0] wq[$];
	int fails, checks_done, tok, abrt, mend, merr, perr, qclr, rcnt, n;

	packet_list_suspend_control dut (.CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .PT_REQ_I(req),
		.PT_ID_I(id), .PT_PRIO_I(prio), .PT_EXT_I(ext), .PT_URGENT_I(urg), .PT_LIST_I(list),
		.PT_ACK_O(ack), .HIPRI_REQ_I(hip), .HIPRI_PRIO_I(hprio), .LOAD_O(load), .RESTORE_O(rest),
		.LOAD_DONE_I(ldone), .LOAD_SUSP_I(lsusp), .XFER_O(xfer), .DATA_CYCLE_I(dcyc),
		.XFER_DONE_I(xdone), .IRQ_BIT_I(irq), .STOP_BIT_I(stop), .NEXT_ADDR_I(nxt),
		.SUSP_REQ_I(sreq), .SRC_FAULT_I(sflt), .DST_FAULT_I(dflt), .XFER_ERR_I(xerr),
		.COL_PEND_I(colp), .LAST_COL_I(lcol), .SVC_REQ_I(svc), .SVC_NOCNT_I(nocnt),
		.SVC_XBAR_I(sxbar), .SVC_EXT_I(sext), .SRC_EXT_I(srcx), .DST_EXT_I(dstx),
		.SRC_STALL_O(sstall), .DST_STALL_O(dstall), .CACHE_REQ_I(creq), .CACHE_MASTER_I(cmas),
		.CACHE_GRANT_O(cgnt), .SAVE_IDX_O(sidx), .SAVE_DATA_I(sdata), .PRAM_WR_O(pw),
		.PRAM_READY_I(prdy), .TOKEN_ADV_O(tok_o), .LOAD_ABORT_O(abrt_o), .MASTER_END_O(mend_o),
		.PP_END_O(pend_o), .MASTER_ERR_O(merr_o), .PP_ERR_O(perr_o), .QUEUE_CLR_O(qclr_o),
		.XPT_DONE_STAT_O(xstat));
	pkt_far_model far (.clk_i(clk), .rstn_i(rstn), .load_i(load), .pram_valid_i(pw.valid),
		.save_idx_i(sidx), .load_done_o(ldone), .pram_ready_o(prdy), .save_data_o(sdata));

	always @(posedge clk) begin
		if (pw.valid === 1'b1 && prdy === 1'b1) wq.push_back({pw.addr, pw.data, pw.prio});
		if (tok_o === 1'b1) tok++;
		if (abrt_o === 1'b1) abrt++;
		if (mend_o === 1'b1) mend++;
		if (merr_o === 1'b1) merr++;
		if (perr_o[0] === 1'b1) perr++;
		if (qclr_o === 1'b1) qclr++;
		if (rest === 1'b1) rcnt++;
	end

	task automatic chk(input logic [97:0] g, input logic [97:0] x);
		checks_done++;
		if (g !== x) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, g, x);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic start_pt(input logic [2:0] i, input logic x, input logic [31:0] l);
		@(negedge clk);
		wq.delete();
		{tok, abrt, mend, merr, perr, qclr, rcnt} = '0;
		@(posedge clk);
		req <= 1'b1;
		id <= i;
		ext <= x;
		list <= l;
		prio <= 2'h1;
		for (n = 0; n < 10 && ack !== 1'b1; n++) @(negedge clk);
		@(posedge clk) req <= 1'b0;
		for (n = 0; n < 20 && xfer !== 1'b1 && !hip; n++) @(negedge clk);
	endtask

	task automatic t_normal();
		@(posedge clk) urg <= 1'b1;
		start_pt(3'h0, 1'b0, 32'h20000080);
		@(posedge clk) {svc, sext, srcx} <= 3'h7;
		@(negedge clk) chk({sstall, dstall}, 2'b10);
		@(posedge clk) {svc, creq} <= 2'b01;
		@(negedge clk) chk({cgnt, sstall, dstall}, 3'b111);
		@(posedge clk) cmas <= 1'b1;
		@(negedge clk) chk({cgnt, sstall, dstall}, 3'b000);
		@(posedge clk) {creq, cmas, irq, stop, xdone} <= 5'h07;
		nxt <= 32'h20000200;
		@(posedge clk) xdone <= 1'b0;
		for (n = 0; n < 30 && wq.size() < 1; n++) @(negedge clk);
		repeat (4) @(negedge clk);
		chk(wq[0], {pkt_list_pkg::MASTER_SUSP_BASE + pkt_list_pkg::LIST_START_OFS,
			32'h0, 32'h20000200, 2'h1});
		chk(mend, 1);
		chk({load, xfer}, 2'b00);
		@(posedge clk) {irq, stop, urg} <= 3'b000;
		$display("Test normal done");
	endtask

	task automatic t_ext();
		start_pt(3'h0, 1'b1, 32'h20000300);
		@(posedge clk) {lcol, creq} <= 2'b11;
		@(negedge clk) chk({xstat, cgnt}, 2'b10);
		@(posedge clk) {lcol, creq, xerr} <= 3'b001;
		@(posedge clk) xerr <= 1'b0;
		repeat (40) @(negedge clk);
		chk(wq.size() + mend + merr + qclr + tok, 0);
		chk(xfer, 1'b0);
		$display("Test external done");
	endtask

	task automatic t_abort();
		@(posedge clk) {hip, hprio} <= 3'h7;
		start_pt(3'h0, 1'b0, 32'h20000100);
		repeat (6) @(negedge clk);
		chk({abrt, wq.size(), xfer}, {32'h1, 32'h0, 1'b0});
		@(posedge clk) hip <= 1'b0;
		$display("Test abort done");
	endtask

	task automatic t_resume();
		@(posedge clk) lsusp <= 1'b1;
		start_pt(3'h0, 1'b0, 32'h20000140);
		chk({merr, qclr, xfer}, {32'h1, 32'h1, 1'b0});
		start_pt(3'h0, 1'b0, 32'h20000180);
		chk({rcnt, xfer}, {32'h4, 1'b1});
		@(posedge clk) {stop, xdone} <= 2'b11;
		@(posedge clk) {xdone, lsusp} <= 2'b00;
		for (n = 0; n < 30 && wq.size() < 1; n++) @(negedge clk);
		repeat (3) @(negedge clk);
		chk({wq.size(), mend, xfer}, {32'h1, 32'h1, 1'b0});
		@(posedge clk) stop <= 1'b0;
		$display("Test resume done");
	endtask

	task automatic run_susp(input int k);
		logic [31:0] b;
		pkt_list_pkg::cause_t cz[5];
		cz = '{pkt_list_pkg::C_REQUEST, pkt_list_pkg::C_PREEMPT, pkt_list_pkg::C_TIMEOUT,
			pkt_list_pkg::C_ERROR, pkt_list_pkg::C_FAULT};
		b = (k == 3) ? pkt_list_pkg::PP_SUSP_BASE : pkt_list_pkg::MASTER_SUSP_BASE;
		start_pt((k == 3) ? 3'h1 : 3'h0, 1'b0, 32'h20000100);
		@(posedge clk);
		colp <= 1'b1;
		sreq <= (k == 0);
		hip <= (k == 1);
		xerr <= (k == 3);
		dflt <= (k == 4);
		for (n = 0; n < 60 && xfer === 1'b1; n++) @(negedge clk);
		if (k == 2) chk(n >= 5 && n <= 8, 1'b1);
		@(posedge clk) {sreq, xerr, dflt} <= 3'h0;
		repeat (4) @(negedge clk);
		chk(wq.size(), 0);
		@(posedge clk) colp <= 1'b0;
		for (n = 0; n < 80 && wq.size() < 17; n++) @(negedge clk);
		repeat (3) @(negedge clk);
		for (int i = 0; i < 16; i++) chk(wq[i][97:66], b + 32'(8 * i));
		chk(wq[0][65:2], {32'h20000100, 29'h0, cz[k]});
		chk(wq[5][65:2], {16'hc3c3, 44'h0, 4'h5});
		chk(wq[16], {b + pkt_list_pkg::LIST_START_OFS, 32'h0, b, (k == 1) ? 2'h3 : 2'h1});
		chk(tok, k != 1);
		chk(perr, k == 3);
		chk(qclr, k == 3);
		chk(wq.size(), 17);
		@(posedge clk) hip <= 1'b0;
		$display("Test suspend %0d done", k);
	endtask

	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		repeat (6000) @(posedge clk);
		fails++;
		finish_test();
	end

	initial begin
		{psel, penable, pwrite, req, ext, urg, hip, xdone, irq, stop, sreq, sflt, dflt} = '0;
		{xerr, colp, lcol, svc, nocnt, sxbar, sext, srcx, dstx, creq, cmas, lsusp} = '0;
		{paddr, pwdata, id, prio, hprio, list, nxt} = '0;
		dcyc = 1'b1;
		rstn = 1'b0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		apb(1'b0, pkt_list_pkg::MIN_OFS, 32'h0);
		chk(r, {8'h0, pkt_list_pkg::RUN_RESET});
		apb(1'b0, pkt_list_pkg::MAX_OFS, 32'h0);
		chk(r, {8'h0, pkt_list_pkg::RUN_RESET});
		apb(1'b0, 8'h40, 32'h0);
		chk({e, r}, {1'b1, 32'h0});
		$display("Test registers done");
		t_normal();
		t_ext();
		t_abort();
		t_resume();
		run_susp(0);
		run_susp(3);
		run_susp(4);
		apb(1'b1, pkt_list_pkg::MIN_OFS, 32'h2);
		apb(1'b1, pkt_list_pkg::MAX_OFS, 32'h3);
		apb(1'b1, pkt_list_pkg::CTRL_OFS, 32'h1);
		apb(1'b0, pkt_list_pkg::CTRL_OFS, 32'h0);
		chk(r, 32'h1);
		apb(1'b0, pkt_list_pkg::MIN_OFS, 32'h0);
		chk(r, 32'h2);
		run_susp(2);
		run_susp(1);
		finish_test();
	end
endmodule
